// File: sim/rxdph_chk.sv
// Checker: bus answers and detector output relations of the receive helpers
`default_nettype none
module rxdph_chk #(
  parameter int unsigned INTERVAL = 256
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic comp_out,
  input wire logic [7:0] rssi_sample,
  input wire logic preamble_detect,
  input wire logic noise_signal,
  input wire logic noise_no_signal,
  input wire logic [7:0] limited_strength
);
  // ----------------------------------------
  // Register shadows
  // ----------------------------------------
  logic [7:0] idx_r, lo_r, hi_r, ctrl_r, det_r, add_r;
  logic wr_r, rd_r, comp_r;
  int quiet_r, edge_r;
  wire take = hsel && hready && htrans[1];
  wire mapped = idx_r inside {8'h0a, 8'h0e, 8'h0f, [8'h17:8'h1c], 8'h1f, 8'h23, 8'h30, 8'h31};
  // Outputs lag a config write by up to two noise intervals
  wire settled = quiet_r > 2 * INTERVAL + 4;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {idx_r, lo_r, hi_r, ctrl_r, det_r, add_r} <= '0;
      {wr_r, rd_r, comp_r} <= '0;
      quiet_r <= 0;
      edge_r <= 0;
    end else begin
      wr_r <= take && hwrite;
      rd_r <= take && !hwrite;
      if (take) idx_r <= haddr[9:2];
      quiet_r <= wr_r ? 0 : quiet_r + 32'(quiet_r < 100000);
      comp_r <= comp_out;
      edge_r <= (comp_out != comp_r) ? 0 : edge_r + 32'(edge_r < 100000);
      if (wr_r && idx_r == rxdph_pkg::IDX_PER_LO) lo_r <= hwdata[7:0];
      if (wr_r && idx_r == rxdph_pkg::IDX_PER_HI) hi_r <= hwdata[7:0];
      if (wr_r && idx_r == rxdph_pkg::IDX_CTRL) ctrl_r <= hwdata[7:0];
      if (wr_r && idx_r == rxdph_pkg::IDX_DETEN) det_r <= hwdata[7:0];
      if (wr_r && idx_r == rxdph_pkg::IDX_NOISE_CFG) add_r <= hwdata[7:0];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_detect_rise;
    !preamble_detect ##1 preamble_detect;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  a_unmapped_zero: assert property (rd_r && !mapped |-> hrdata == 32'h0) else $error("unmapped read nonzero");
  a_period_low: assert property (rd_r && idx_r == rxdph_pkg::IDX_PER_LO |-> hrdata[7:0] == lo_r)
    else $error("period low readback wrong");
  a_period_high: assert property (rd_r && idx_r == rxdph_pkg::IDX_PER_HI |-> hrdata[7:0] == hi_r)
    else $error("period high and margin readback wrong");
  a_add_only_quiet: assert property (settled && !det_r[5] && add_r[0] |-> !noise_signal)
    else $error("signal judgment with addition only");
  a_both_off_idle: assert property (settled && !det_r[5] && !add_r[0] |-> !noise_signal && !noise_no_signal)
    else $error("noise judgment with both disabled");
  a_ask_no_noise: assert property (settled && ctrl_r[4] |-> !noise_signal)
    else $error("noise judgment in ASK");
  a_fsk_passthru: assert property (settled && !ctrl_r[4] |-> limited_strength == $past(rssi_sample))
    else $error("strength altered outside ASK");
  a_preamble_edges: assert property (s_detect_rise |-> edge_r < 1000)
    else $error("preamble detect without recent edge");
endmodule
bind rxdph_top rxdph_chk #(.INTERVAL(INTERVAL)) i_chk (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .comp_out(comp_out), .rssi_sample(rssi_sample), .preamble_detect(preamble_detect),
  .noise_signal(noise_signal), .noise_no_signal(noise_no_signal), .limited_strength(limited_strength));
`default_nettype wire

// File: sim/tb_top.sv
// Testbench: register access, noise addition, preamble timing and ASK peak hold
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Preamble tick: cutoff 0 gives fbc = ref/40, tick is twice fbc
  localparam int TICK = rxdph_pkg::REF_DIV * 20;
  logic clk, reset_n, hsel, hwrite, comp_out, hf_input;
  logic hreadyout, hresp, preamble_detect, noise_signal, noise_no_signal;
  logic [31:0] haddr, hwdata, hrdata, rd, p;
  logic [1:0] htrans;
  logic [7:0] rssi_sample, rate_filter_out, limited_strength, lim;
  int failures, check_count;
  rxdph_top #(.INTERVAL(16)) i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .comp_out(comp_out), .hf_input(hf_input), .noise_level_in(8'h00), .rssi_sample(rssi_sample),
    .rate_filter_out(rate_filter_out), .preamble_detect(preamble_detect), .noise_signal(noise_signal),
    .noise_no_signal(noise_no_signal), .limited_strength(limited_strength));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      failures++;
      final_report();
    end
  endtask
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reg_test();
    chk({hreadyout, hresp, preamble_detect, noise_signal, noise_no_signal}, 32'h10);
    bus(rxdph_pkg::IDX_PER_LO, 1'b1, 8'ha5);
    bus(rxdph_pkg::IDX_PER_HI, 1'b1, 8'hff);
    bus(rxdph_pkg::IDX_PER_LO, 1'b0, 8'h00);
    chk(rd, 32'ha5);
    bus(rxdph_pkg::IDX_PER_HI, 1'b0, 8'h00);
    chk(rd, 32'hff);
    bus(8'h3e, 1'b0, 8'h00);
    chk(rd, 32'h0);
  endtask
  // Both high-frequency detector settings must give the same readback
  task automatic noise_test();
    for (int hd = 0; hd < 2; hd++) begin
      do_reset();
      rssi_sample <= 8'h3c;
      bus(rxdph_pkg::IDX_DETEN, 1'b1, 8'(hd << rxdph_pkg::BIT_HFDET_EN));
      bus(rxdph_pkg::IDX_NOISE_CFG, 1'b1, 8'h01);
      hf_input <= 1'b1;
      repeat (48) @(posedge clk);
      bus(rxdph_pkg::IDX_NOISE_MON, 1'b0, 8'h00);
      chk(rd[7:0], rxdph_pkg::NOISE_ADD_FULL);
      // Square wave of one interval period: every window is half high
      fork
        repeat (12) begin
          hf_input <= ~hf_input;
          repeat (8) @(posedge clk);
        end
        begin
          repeat (64) @(posedge clk);
          bus(rxdph_pkg::IDX_NOISE_MON, 1'b0, 8'h00);
        end
      join
      chk(rd[7:0], rxdph_pkg::NOISE_ADD_HALF);
      chk(noise_signal, 1'b0);
    end
  endtask
  task automatic pre_test(input logic trig, input logic [8:0] per, input logic exp);
    logic seen;
    do_reset();
    seen = 1'b0;
    bus(rxdph_pkg::IDX_FILT, 1'b1, 8'h00);
    bus(rxdph_pkg::IDX_DETEN, 1'b1, 8'h40);
    bus(rxdph_pkg::IDX_PER_LO, 1'b1, per[7:0]);
    bus(rxdph_pkg::IDX_PER_HI, 1'b1, {per[8], 7'h02});
    bus(rxdph_pkg::IDX_PRE_CFG, 1'b1, {5'h0, trig, 2'b00});
    repeat (14) begin
      comp_out <= ~comp_out;
      repeat (4 * TICK) begin
        @(posedge clk);
        seen = seen | (preamble_detect === 1'b1);
      end
    end
    chk(seen, exp);
  endtask
  task automatic ask_test();
    do_reset();
    bus(rxdph_pkg::IDX_CTRL, 1'b1, 8'h10);
    bus(rxdph_pkg::IDX_DETEN, 1'b1, 8'h20);
    bus(rxdph_pkg::IDX_QC, 1'b1, 8'h01);
    bus(rxdph_pkg::IDX_PEAK_CFG, 1'b1, 8'he0);
    rssi_sample <= 8'h00;
    rate_filter_out <= 8'hc8;
    repeat (8000) @(posedge clk);
    bus(rxdph_pkg::IDX_PEAK_MON, 1'b0, 8'h00);
    p = rd;
    chk(p[7:0] != 8'h00 && p <= 32'hc8, 1'b1);
    rate_filter_out <= 8'h00;
    repeat (400) @(posedge clk);
    lim = limited_strength;
    bus(rxdph_pkg::IDX_PEAK_MON, 1'b0, 8'h00);
    chk(rd <= p, 1'b1);
    chk(lim >= rd[8:1], 1'b1);
    bus(rxdph_pkg::IDX_QC, 1'b1, 8'h00);
    repeat (8000) @(posedge clk);
    chk(limited_strength < 8'h04, 1'b1);
    rssi_sample <= 8'h80;
    repeat (8000) @(posedge clk);
    chk(limited_strength >= 8'h7e && limited_strength <= 8'h80, 1'b1);
  endtask
  initial begin
    {reset_n, hsel, hwrite, comp_out, hf_input} = '0;
    {haddr, hwdata} = '0;
    htrans = 2'b00;
    rssi_sample = 8'h00;
    rate_filter_out = 8'h00;
    failures = 0;
    check_count = 0;
    do_reset();
    reg_test();
    noise_test();
    pre_test(1'b0, 9'd8, 1'b1);
    pre_test(1'b1, 9'd9, 1'b1);
    pre_test(1'b0, 9'd4, 1'b0);
    ask_test();
    final_report();
  end
endmodule
`default_nettype wire

// File: src/rxdph_pkg.sv
// Package: register map, field positions, constants and timing of the receive helpers
`default_nettype none
package rxdph_pkg;
  // Register indexes; printed offsets are not all multiples of four, so address = 4 x index
  localparam logic [7:0] IDX_CTRL = 8'h0a;
  localparam logic [7:0] IDX_FILT = 8'h0e;
  localparam logic [7:0] IDX_DETEN = 8'h0f;
  localparam logic [7:0] IDX_PER_LO = 8'h17;
  localparam logic [7:0] IDX_PER_HI = 8'h18;
  localparam logic [7:0] IDX_NOISE_CFG = 8'h19;
  localparam logic [7:0] IDX_PRE_CFG = 8'h1a;
  localparam logic [7:0] IDX_QC = 8'h1b;
  localparam logic [7:0] IDX_PEAK_CFG = 8'h1c;
  localparam logic [7:0] IDX_PEAK_MON = 8'h1f;
  localparam logic [7:0] IDX_NOISE_MON = 8'h23;
  localparam logic [7:0] IDX_SAMPLE = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  // Field positions
  localparam int unsigned BIT_ASK = 4;
  localparam int unsigned BIT_NOISE_EN = 5;
  localparam int unsigned BIT_HFDET_EN = 4;
  localparam int unsigned BIT_ADD_EN = 0;
  localparam int unsigned BIT_TRIG = 2;
  localparam int unsigned BIT_PER8 = 7;
  localparam int unsigned BIT_QC2_EN = 0;
  // Constants
  localparam logic [7:0] NOISE_ADD_HALF = 8'h28;
  localparam logic [7:0] NOISE_ADD_FULL = 8'h51;
  localparam logic [7:0] LIMIT_SHIFT = 8'h01;
  localparam real REF_CLK_MHZ = 30.32;
  localparam real CLK_MHZ = 200.0;
  // Cycles of clk per 30.32 MHz reference tick (rounded down)
  localparam int unsigned REF_DIV = int'(CLK_MHZ / REF_CLK_MHZ - 0.5);
  localparam logic [7:0] INTERVAL_LEN = 8'hff;

  typedef struct packed {
    logic ask;
    logic noise_en;
    logic add_en;
    logic trig_opposite;
    logic qc2_en;
    logic [3:0] cutoff;
    logic [8:0] period;
    logic [6:0] margin;
    logic [1:0] pre_count;
    logic [1:0] charge;
    logic [2:0] discharge;
  } rxdph_cfg_s;
endpackage
`default_nettype wire

// File: src/rxdph_top.sv
// Receive helpers: noise addition, preamble detector, ASK limiter and peak hold, AHB-Lite slave
// How it works
// - add constant to noise when high frequency
// - addition ignores detector and enable selects
// - addition alone yields only no-signal judgment
// - monitor reads 40 half, 81 full
// - works with pulse-count or delay detector
// - count clocks between edges against period±margin
// - counting clock is twice filter clock
// - trigger 0: rising to rising, full period
// - trigger 1: opposite edges, half period
// - margin is never halved
// - period nine bits, margin seven bits
// - ASK strength digitised and low-pass filtered
// - limiter keeps strength above peak-derived level
// - limiter only with quick-charge 2
// - peak hold tracks with coefficient time constants
// - charging coefficient is reciprocal-sum combination
// - rising uses both, falling uses discharge
// - peak level readable as 8 bits
// - ASK disables noise-based detection
// - filter clock divided from reference clock
// - detect after consecutive in-margin periods
//
// ---------------------------------------------------------------
// Register indexes
// ---------------------------------------------------------------
// 0x0a control: bit 4 selects ASK
// 0x0e filter: bits 4:1 cutoff step
// 0x0f detector enables: bit 5 noise
// 0x17 preamble period, low eight bits
// 0x18 bit 7 period top bit, bits 6:0 margin
// 0x19 bit 0 high-frequency noise addition
// 0x1a bit 2 edge mode, bits 4:3 check count
// 0x1b bit 0 quick-charge 2 in use
// 0x1c bits 4:3 charge, bits 7:5 discharge
// 0x1f peak level, read only
// 0x23 noise level, read only
// 0x30 noise threshold
// 0x31 status: no-signal, signal, preamble
//
// ---------------------------------------------------------------
// Interfaces and timing
// ---------------------------------------------------------------
// Bus: AHB-Lite slave, zero wait states, OKAY only
// Register byte address is four times its index
// Reads are registered at the address phase edge,
// so hrdata stands for the whole data phase
// Writes land at the end of the data phase
// Only bits 7:0 of each word are kept
// Unmapped indexes read zero; writes to them vanish
// hsize is not checked: only whole words are expected
//
// Filter clock: clk is divided to a reference tick,
// the reference tick by the cutoff step
// The preamble count tick is twice the filter clock
// Reference tick is a whole divisor of clk,
// so the filter clock is only as exact as that division
//
// Preamble: edges of comp_out are seen on the first clk edge that samples them
// The first qualifying edge only arms the detector
// Each later edge ends one interval and restarts the count
// Count saturates so a stalled comparator never wraps
// Detect drops on the first interval out of margin
//
// Noise: one detection interval is INTERVAL clk cycles
// High-frequency cycles of the whole interval set the addition
// Monitor and both judgments change only at interval end
//
// ASK: low-pass runs on the reference tick,
// peak hold on the filter clock, limiter on every clk
// Peak hold rests in FSK and keeps its last level
// Limiter level is half the peak level
// Limitation: coefficients are powers of two,
// so time constants move in coarse steps
//
// Decided for this implementation: the AHB-Lite slave port.
`default_nettype none
module rxdph_top #(
  parameter int unsigned INTERVAL = 256
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic comp_out,
  input wire logic hf_input,
  input wire logic [7:0] noise_level_in,
  input wire logic [7:0] rssi_sample,
  input wire logic [7:0] rate_filter_out,
  output logic preamble_detect,
  output logic noise_signal,
  output logic noise_no_signal,
  output logic [7:0] limited_strength
);
  // Interval counters are 16 bits wide and need at least two cycles
  if (INTERVAL < 2 || INTERVAL > 65536) begin : g_bad_interval
    $error("INTERVAL out of range");
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r, filt_r, deten_r, per_lo_r, per_hi_r, ncfg_r, pcfg_r, qc_r, pkcfg_r, nthr_r;
  logic [7:0] peak_r, noise_mon_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [31:0] hrdata_nxt;
  wire logic take = hsel && hready && htrans[1];
  wire logic [7:0] acc_idx = haddr[9:2];
  wire rxdph_pkg::rxdph_cfg_s cfg = '{
    ask: ctrl_r[rxdph_pkg::BIT_ASK],
    noise_en: deten_r[rxdph_pkg::BIT_NOISE_EN],
    add_en: ncfg_r[rxdph_pkg::BIT_ADD_EN],
    trig_opposite: pcfg_r[rxdph_pkg::BIT_TRIG],
    qc2_en: qc_r[rxdph_pkg::BIT_QC2_EN],
    cutoff: filt_r[4:1],
    period: {per_hi_r[rxdph_pkg::BIT_PER8], per_lo_r},
    margin: per_hi_r[6:0],
    pre_count: pcfg_r[4:3],
    charge: pkcfg_r[4:3],
    discharge: pkcfg_r[7:5]};

  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    unique case (acc_idx)
      rxdph_pkg::IDX_CTRL: hrdata_nxt[7:0] = ctrl_r;
      rxdph_pkg::IDX_FILT: hrdata_nxt[7:0] = filt_r;
      rxdph_pkg::IDX_DETEN: hrdata_nxt[7:0] = deten_r;
      rxdph_pkg::IDX_PER_LO: hrdata_nxt[7:0] = per_lo_r;
      rxdph_pkg::IDX_PER_HI: hrdata_nxt[7:0] = per_hi_r;
      rxdph_pkg::IDX_NOISE_CFG: hrdata_nxt[7:0] = ncfg_r;
      rxdph_pkg::IDX_PRE_CFG: hrdata_nxt[7:0] = pcfg_r;
      rxdph_pkg::IDX_QC: hrdata_nxt[7:0] = qc_r;
      rxdph_pkg::IDX_PEAK_CFG: hrdata_nxt[7:0] = pkcfg_r;
      rxdph_pkg::IDX_PEAK_MON: hrdata_nxt[7:0] = peak_r;
      rxdph_pkg::IDX_NOISE_MON: hrdata_nxt[7:0] = noise_mon_r;
      rxdph_pkg::IDX_SAMPLE: hrdata_nxt[7:0] = nthr_r;
      rxdph_pkg::IDX_STATUS: hrdata_nxt[2:0] = {noise_no_signal, noise_signal, preamble_detect};
      default: hrdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite;
      wr_idx_r <= acc_idx;
      if (take && !hwrite) begin
        hrdata <= hrdata_nxt;
      end
    end
  end

  wire logic [7:0] wd = hwdata[7:0];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= 8'h00;
      filt_r <= 8'h00;
      deten_r <= 8'h00;
      per_lo_r <= 8'h00;
      per_hi_r <= 8'h00;
      ncfg_r <= 8'h00;
      pcfg_r <= 8'h00;
      qc_r <= 8'h00;
      pkcfg_r <= 8'h00;
      nthr_r <= 8'h00;
    end else if (wr_pend_r) begin
      unique case (wr_idx_r)
        rxdph_pkg::IDX_CTRL: ctrl_r <= wd;
        rxdph_pkg::IDX_FILT: filt_r <= wd;
        rxdph_pkg::IDX_DETEN: deten_r <= wd;
        rxdph_pkg::IDX_PER_LO: per_lo_r <= wd;
        rxdph_pkg::IDX_PER_HI: per_hi_r <= wd;
        rxdph_pkg::IDX_NOISE_CFG: ncfg_r <= wd;
        rxdph_pkg::IDX_PRE_CFG: pcfg_r <= wd;
        rxdph_pkg::IDX_QC: qc_r <= wd;
        rxdph_pkg::IDX_PEAK_CFG: pkcfg_r <= wd;
        rxdph_pkg::IDX_SAMPLE: nthr_r <= wd;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Filter clock: reference tick divided by cutoff setting
  // ---------------------------------------------------------------
  // Reference ticks per preamble count tick (twice fbc); fbc = 30.32 MHz / 40 at the top step
  function automatic logic [9:0] pre_div(input logic [3:0] sel);
    unique case (sel[3:1])
      3'b000: pre_div = 10'd20;
      3'b001: pre_div = 10'd40;
      3'b010: pre_div = 10'd80;
      3'b011: pre_div = 10'd160;
      3'b100: pre_div = 10'd320;
      3'b101: pre_div = 10'd640;
      default: pre_div = 10'd20;
    endcase
  endfunction

  logic [2:0] ref_cnt_r;
  logic [9:0] div_cnt_r;
  logic pre_tick_r, fbc_tick_r, fbc_phase_r;
  // Counter runs 0..REF_DIV-1: one tick every REF_DIV cycles
  wire logic ref_tick = (ref_cnt_r == 3'(rxdph_pkg::REF_DIV - 1));
  wire logic [9:0] div_top = pre_div(cfg.cutoff) - 10'd1;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_cnt_r <= 3'h0;
      div_cnt_r <= 10'h000;
      pre_tick_r <= 1'b0;
      fbc_tick_r <= 1'b0;
      fbc_phase_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_tick ? 3'h0 : ref_cnt_r + 3'h1;
      pre_tick_r <= 1'b0;
      fbc_tick_r <= 1'b0;
      if (ref_tick) begin
        if (div_cnt_r >= div_top) begin
          div_cnt_r <= 10'h000;
          pre_tick_r <= 1'b1;
          fbc_phase_r <= ~fbc_phase_r;
          fbc_tick_r <= fbc_phase_r;
        end else begin
          div_cnt_r <= div_cnt_r + 10'h001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Preamble detector
  // ---------------------------------------------------------------
  logic comp_d_r;
  logic [9:0] pcnt_r;
  logic [3:0] good_r;
  logic armed_r;
  wire logic rise = comp_out && !comp_d_r;
  wire logic fall = !comp_out && comp_d_r;
  wire logic qual = cfg.trig_opposite ? (rise || fall) : rise;
  wire logic [8:0] target = cfg.trig_opposite ? {1'b0, cfg.period[8:1]} : cfg.period;
  wire logic [10:0] lo_lim = {2'b00, target} - {4'h0, cfg.margin};
  wire logic [10:0] hi_lim = {2'b00, target} + {4'h0, cfg.margin};
  wire logic in_win = !lo_lim[10] ? ({1'b0, pcnt_r} >= lo_lim && {1'b0, pcnt_r} <= hi_lim)
                                  : ({1'b0, pcnt_r} <= hi_lim);
  // Checks needed: periods 3..6 in period mode, bits 6..12 in bit mode
  wire logic [3:0] need = cfg.trig_opposite ? 4'(6 + 2 * cfg.pre_count) : 4'(3 + cfg.pre_count);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      comp_d_r <= 1'b0;
      pcnt_r <= 10'h000;
      good_r <= 4'h0;
      armed_r <= 1'b0;
      preamble_detect <= 1'b0;
    end else begin
      comp_d_r <= comp_out;
      if (qual) begin
        pcnt_r <= 10'h000;
        armed_r <= 1'b1;
        if (armed_r && in_win) begin
          good_r <= (good_r == 4'hf) ? good_r : good_r + 4'h1;
          // Widened so a saturated run count cannot wrap to zero
          preamble_detect <= ({1'b0, good_r} + 5'h01 >= {1'b0, need});
        end else begin
          good_r <= 4'h0;
          preamble_detect <= 1'b0;
        end
      end else if (pre_tick_r && pcnt_r != 10'h3ff) begin
        pcnt_r <= pcnt_r + 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Noise detection with high-frequency addition
  // ---------------------------------------------------------------
  // Addition scales with the share of the interval spent at high frequency
  logic [15:0] icnt_r, hcnt_r;
  logic [7:0] noise_max_r;
  wire logic int_end = (icnt_r == 16'(INTERVAL - 1));
  // The closing cycle counts too, so any half-filled window reaches half
  wire logic [16:0] hf_total = {1'b0, hcnt_r} + {16'h0000, hf_input};
  wire logic [16:0] half_int = 17'(INTERVAL / 2);
  wire logic [7:0] add_amt = (hf_total >= 17'(INTERVAL)) ? rxdph_pkg::NOISE_ADD_FULL :
                             (hf_total >= half_int) ? rxdph_pkg::NOISE_ADD_HALF : 8'h00;
  wire logic add_on = cfg.add_en && !cfg.ask;
  wire logic [8:0] noise_sum = {1'b0, cfg.noise_en ? noise_max_r : 8'h00} + {1'b0, add_on ? add_amt : 8'h00};
  wire logic [7:0] noise_sat = noise_sum[8] ? 8'hff : noise_sum[7:0];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      icnt_r <= 16'h0000;
      hcnt_r <= 16'h0000;
      noise_max_r <= 8'h00;
      noise_mon_r <= 8'h00;
      noise_signal <= 1'b0;
      noise_no_signal <= 1'b0;
    end else if (int_end) begin
      icnt_r <= 16'h0000;
      hcnt_r <= 16'h0000;
      noise_max_r <= 8'h00;
      noise_mon_r <= noise_sat;
      // Low noise means signal; the addition alone can only judge no-signal
      noise_signal <= !cfg.ask && cfg.noise_en && noise_sat < nthr_r;
      noise_no_signal <= !cfg.ask && (cfg.noise_en || add_on) && noise_sat >= nthr_r;
    end else begin
      icnt_r <= icnt_r + 16'h0001;
      hcnt_r <= hcnt_r + {15'h0000, hf_input};
      noise_max_r <= (noise_level_in > noise_max_r) ? noise_level_in : noise_max_r;
    end
  end

  // ---------------------------------------------------------------
  // ASK path: 40 kHz low-pass, limiter, peak hold
  // ---------------------------------------------------------------
  // One-pole IIR on the reference tick; a shift of 7 puts the corner near 40 kHz
  logic [15:0] lpf_r;
  logic [15:0] peak_acc_r;
  wire logic [16:0] lpf_diff = {1'b0, rssi_sample, 8'h00} - {1'b0, lpf_r};
  // Sign-extended shift so the filter falls as well as rises
  wire logic [16:0] lpf_step = {{7{lpf_diff[16]}}, lpf_diff[16:7]};
  wire logic [7:0] lpf_out = lpf_r[15:8];
  wire logic [7:0] limit_lvl = peak_r >> rxdph_pkg::LIMIT_SHIFT;
  wire logic [7:0] lim_nxt = (cfg.qc2_en && lpf_out < limit_lvl) ? limit_lvl : lpf_out;
  // Combined coefficient 1/(1/tp+1/tr) = tp*tr/(tp+tr), as shift counts: tp=2^(c+2), tr=2^(d+5)
  function automatic logic [15:0] peak_step(input logic [15:0] acc, input logic [7:0] x,
                                            input logic [1:0] c, input logic [2:0] d);
    logic [16:0] diff;
    logic [15:0] mag;
    diff = {1'b0, x, 8'h00} - {1'b0, acc};
    mag = diff[16] ? (acc - {x, 8'h00}) : diff[15:0];
    if (!diff[16]) begin
      // rising: both rates add, equal to the combined coefficient
      peak_step = acc + (mag >> (4'(c) + 4'd2)) + (mag >> (4'(d) + 4'd5));
    end else begin
      peak_step = acc - (mag >> (4'(d) + 4'd5));
    end
  endfunction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lpf_r <= 16'h0000;
      peak_acc_r <= 16'h0000;
      peak_r <= 8'h00;
      limited_strength <= 8'h00;
    end else begin
      if (ref_tick && cfg.ask) begin
        lpf_r <= lpf_r + lpf_step[15:0];
      end
      if (fbc_tick_r && cfg.ask) begin
        peak_acc_r <= peak_step(peak_acc_r, rate_filter_out, cfg.charge, cfg.discharge);
      end
      peak_r <= peak_acc_r[15:8];
      limited_strength <= cfg.ask ? lim_nxt : rssi_sample;
    end
  end
endmodule
`default_nettype wire
